// >>> cmpg_defines.svh
`ifndef CMPG_DEFINES_SVH
`define CMPG_DEFINES_SVH

// memory sizes and partition borders, byte addresses within each array
`define CMPG_ROM_BYTES 18'h38000
`define CMPG_ROM_APP_BYTES 18'h32000
`define CMPG_RAM_BYTES 18'h01800
`define CMPG_RAM_SMALL_BYTES 18'h00080
`define CMPG_RAM_COP_START 18'h00e00
`define CMPG_NV_BYTES 18'h0a000
`define CMPG_NV_MFR_BYTES 18'h00080
`define CMPG_NV_SUPFW_1K 18'h00400
`define CMPG_NV_SUPFW_4K 18'h01000

// vector placement in rom
`define CMPG_IRQ_VEC_BASE 18'h00003
`define CMPG_SYS_CALL_BASE 18'h00200
`define CMPG_CFG_CALL_BASE 18'h32000
`define CMPG_CFG_CALLS 5'h08

// reset values
`define CMPG_NV_CFG_RST 2'h3
`define CMPG_RAM_CFG_RST 1'h1
`define CMPG_USER_LO_RST 18'h3ffff
`define CMPG_USER_HI_RST 18'h00000
`define CMPG_SFR_MASK_RST 8'h00

`endif

// >>> cmpg_pkg.sv
package cmpg_pkg;

   typedef enum logic [2:0] {
      mode_boot = 3'b000,
      mode_test = 3'b001,
      mode_supfw = 3'b010,
      mode_system = 3'b011,
      mode_user = 3'b100
   } cmpg_mode_t;

   typedef enum logic [1:0] {
      space_rom = 2'b00,
      space_ram = 2'b01,
      space_nv = 2'b10,
      space_none = 2'b11
   } cmpg_space_t;

   typedef enum logic [1:0] {
      pwr_run = 2'b00,
      pwr_idle = 2'b01,
      pwr_sleep = 2'b10
   } cmpg_pwr_t;

endpackage

// >>> cmpg_region_if.sv
`timescale 1ns/10ps
`default_nettype none

interface cmpg_region_if;
   cmpg_pkg::cmpg_space_t space;
   logic [17:0] addr;
   logic [1:0] nv_cfg;
   logic ram_small;
   logic in_range;
   logic in_small;
   logic in_cop;

   modport dec (input space, input addr, input nv_cfg, input ram_small,
                output in_range, output in_small, output in_cop);
   modport user (output space, output addr, output nv_cfg, output ram_small,
                 input in_range, input in_small, input in_cop);
endinterface

`default_nettype wire

// >>> cmpg_region_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmpg_defines.svh"

module cmpg_region_decode (
   cmpg_region_if.dec rif
);

   logic [17:0] nv_small;
   logic [17:0] ram_small;

   always_comb begin
      // reserved nonvolatile part: manufacturer bytes plus support firmware share
      unique case (rif.nv_cfg)
         2'h0: nv_small = `CMPG_NV_MFR_BYTES;
         2'h1: nv_small = `CMPG_NV_MFR_BYTES + `CMPG_NV_SUPFW_1K;
         default: nv_small = `CMPG_NV_MFR_BYTES + `CMPG_NV_SUPFW_4K;
      endcase
      ram_small = rif.ram_small ? `CMPG_RAM_SMALL_BYTES : 18'h00000;
   end

   always_comb begin
      rif.in_range = 1'b0;
      rif.in_small = 1'b0;
      rif.in_cop = 1'b0;
      unique case (rif.space)
         cmpg_pkg::space_rom: begin
            rif.in_range = rif.addr < `CMPG_ROM_BYTES;
            // test rom sits above the application part
            rif.in_small = rif.addr >= `CMPG_ROM_APP_BYTES;
         end
         cmpg_pkg::space_ram: begin
            rif.in_range = rif.addr < `CMPG_RAM_BYTES;
            rif.in_small = rif.addr < ram_small;
            rif.in_cop = rif.addr >= `CMPG_RAM_COP_START;
         end
         cmpg_pkg::space_nv: begin
            rif.in_range = rif.addr < `CMPG_NV_BYTES;
            rif.in_small = rif.addr < nv_small;
            rif.in_cop = 1'b1;
         end
         default: begin
            rif.in_range = 1'b0;
         end
      endcase
   end

endmodule

`default_nettype wire

// >>> cmpg_guard.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmpg_defines.svh"

module cmpg_guard #(
   parameter int SFR_GROUPS = 8,
   parameter logic [31:0] USER_VEC_MASK = 32'h00000000
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // pins: test fuse and configuration straps
   input wire logic test_fuse_pin,
   input wire logic [1:0] nv_cfg_pin,
   input wire logic ram_cfg_pin,
   // core control events
   input wire logic boot_done,
   input wire logic test_lock_req,
   input wire logic vec_take,
   input wire logic [4:0] vec_src,
   input wire logic call_req,
   input wire logic call_cfg,
   input wire logic [4:0] call_num,
   input wire logic call_ret,
   input wire logic user_enter,
   // window and sfr grant programming
   input wire logic mmu_wr,
   input wire cmpg_pkg::cmpg_space_t mmu_space,
   input wire logic [17:0] mmu_lo,
   input wire logic [17:0] mmu_hi,
   input wire logic sfr_wr,
   input wire logic [SFR_GROUPS-1:0] sfr_mask,
   // power requests
   input wire logic idle_req,
   input wire logic sleep_req,
   input wire logic wake,
   // cpu access
   input wire logic cpu_req,
   input wire cmpg_pkg::cmpg_space_t cpu_space,
   input wire logic [17:0] cpu_addr,
   input wire logic cpu_we,
   input wire logic [7:0] cpu_wdata,
   // coprocessor access
   input wire logic cop_req,
   input wire cmpg_pkg::cmpg_space_t cop_space,
   input wire logic [17:0] cop_addr,
   input wire logic cop_we,
   // memory read return for cpu
   input wire logic mem_rvalid,
   input wire logic [7:0] mem_rdata,
   // state outputs
   output cmpg_pkg::cmpg_mode_t mode,
   output logic test_enabled,
   output logic fuse_blow,
   output logic vec_load,
   output logic [17:0] vec_pc,
   output logic priv_refused,
   output logic [SFR_GROUPS-1:0] sfr_allow,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   // memory side for cpu
   output logic mem_req,
   output cmpg_pkg::cmpg_space_t mem_space,
   output logic [17:0] mem_addr,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic cpu_fault,
   output logic cpu_rvalid,
   output logic [7:0] cpu_rdata,
   // memory side for coprocessor
   output logic cop_mem_req,
   output cmpg_pkg::cmpg_space_t cop_mem_space,
   output logic [17:0] cop_mem_addr,
   output logic cop_mem_we,
   output logic cop_fault
);

   cmpg_pkg::cmpg_mode_t mode_r;
   cmpg_pkg::cmpg_pwr_t pwr_r;
   logic fuse_meta_r, fuse_sync_r;
   logic [2:0] cfg_meta_r, cfg_sync_r;
   logic cfg_taken_r;
   logic [1:0] nv_cfg_r;
   logic ram_cfg_r;
   logic test_enabled_r, locked_r, fuse_blow_r;
   logic vec_load_r, priv_refused_r;
   logic [17:0] vec_pc_r;
   logic [SFR_GROUPS-1:0] sfr_mask_r, sfr_allow_r;
   logic [17:0] user_lo_r [3];
   logic [17:0] user_hi_r [3];
   logic [2:0] user_in;
   logic sysuser, cpu_allow, cop_allow, user_hit;
   logic mem_req_r, mem_we_r, cpu_fault_r, cpu_rvalid_r;
   cmpg_pkg::cmpg_space_t mem_space_r, cop_mem_space_r;
   logic [17:0] mem_addr_r, cop_mem_addr_r;
   logic [7:0] mem_wdata_r, cpu_rdata_r;
   logic cop_mem_req_r, cop_mem_we_r, cop_fault_r;
   logic cpu_clk_en_r, periph_clk_en_r;

   cmpg_region_if cpu_rif ();
   cmpg_region_if cop_rif ();

   assign cpu_rif.space = cpu_space;
   assign cpu_rif.addr = cpu_addr;
   assign cpu_rif.nv_cfg = nv_cfg_r;
   assign cpu_rif.ram_small = ram_cfg_r;
   assign cop_rif.space = cop_space;
   assign cop_rif.addr = cop_addr;
   assign cop_rif.nv_cfg = nv_cfg_r;
   assign cop_rif.ram_small = ram_cfg_r;

   cmpg_region_decode u_cpu_dec (
      .rif(cpu_rif.dec)
   );

   cmpg_region_decode u_cop_dec (
      .rif(cop_rif.dec)
   );

   // pins cross into the clock domain through two flops
   always_ff @(posedge clk) begin
      fuse_meta_r <= test_fuse_pin;
      fuse_sync_r <= fuse_meta_r;
      cfg_meta_r <= {nv_cfg_pin, ram_cfg_pin};
      cfg_sync_r <= cfg_meta_r;
   end

   // straps caught once after reset release; reset value is the most protective split
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_taken_r <= 1'b0;
         nv_cfg_r <= `CMPG_NV_CFG_RST;
         ram_cfg_r <= `CMPG_RAM_CFG_RST;
      end else if (!cfg_taken_r) begin
         cfg_taken_r <= 1'b1;
         nv_cfg_r <= cfg_sync_r[2:1];
         ram_cfg_r <= cfg_sync_r[0];
      end
   end

   // lock pulse blows the fuse; the fuse pin then keeps test off across resets
   always_ff @(posedge clk) begin
      if (reset) begin
         locked_r <= 1'b0;
         fuse_blow_r <= 1'b0;
         test_enabled_r <= 1'b0;
      end else begin
         fuse_blow_r <= test_lock_req && mode_r == cmpg_pkg::mode_test;
         if (test_lock_req && mode_r == cmpg_pkg::mode_test) begin
            locked_r <= 1'b1;
         end
         // a lock request outside test mode is ignored, so it must not drop test_enabled
         test_enabled_r <= !fuse_sync_r && !locked_r && !(test_lock_req && mode_r == cmpg_pkg::mode_test);
      end
   end

   assign sysuser = mode_r == cmpg_pkg::mode_system || mode_r == cmpg_pkg::mode_user;

   // mode register has no software path; only these events move it
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_r <= cmpg_pkg::mode_boot;
      end else if (test_lock_req && mode_r == cmpg_pkg::mode_test) begin
         mode_r <= cmpg_pkg::mode_system;
      end else if (mode_r == cmpg_pkg::mode_boot && boot_done) begin
         mode_r <= test_enabled_r ? cmpg_pkg::mode_test : cmpg_pkg::mode_system;
      end else if (sysuser && vec_take) begin
         mode_r <= USER_VEC_MASK[vec_src] ? cmpg_pkg::mode_user : cmpg_pkg::mode_system;
      end else if (sysuser && call_req && call_cfg && call_num < `CMPG_CFG_CALLS) begin
         mode_r <= cmpg_pkg::mode_supfw;
      end else if (sysuser && call_req && !call_cfg) begin
         mode_r <= cmpg_pkg::mode_system;
      end else if (mode_r == cmpg_pkg::mode_supfw && call_ret) begin
         mode_r <= cmpg_pkg::mode_system;
      end else if (mode_r == cmpg_pkg::mode_system && user_enter) begin
         mode_r <= cmpg_pkg::mode_user;
      end
   end

   // vector program counter; vectors and calls only act from system or user mode
   always_ff @(posedge clk) begin
      if (reset) begin
         vec_load_r <= 1'b0;
         vec_pc_r <= 18'h00000;
      end else begin
         vec_load_r <= 1'b0;
         if (sysuser && vec_take) begin
            vec_load_r <= 1'b1;
            vec_pc_r <= `CMPG_IRQ_VEC_BASE + {10'h000, vec_src, 3'h0};
         end else if (sysuser && call_req && call_cfg && call_num < `CMPG_CFG_CALLS) begin
            vec_load_r <= 1'b1;
            vec_pc_r <= `CMPG_CFG_CALL_BASE + {10'h000, call_num, 3'h0};
         end else if (sysuser && call_req && !call_cfg) begin
            vec_load_r <= 1'b1;
            vec_pc_r <= `CMPG_SYS_CALL_BASE + {10'h000, call_num, 3'h0};
         end
      end
   end

   // attempts that need system mode but arrive elsewhere, calls from outside system or user mode, bad configuration call numbers
   always_ff @(posedge clk) begin
      if (reset) begin
         priv_refused_r <= 1'b0;
      end else begin
         priv_refused_r <= ((mmu_wr || sfr_wr || user_enter) && mode_r != cmpg_pkg::mode_system)
            || (call_req && (!sysuser || (call_cfg && call_num >= `CMPG_CFG_CALLS)));
      end
   end

   // user windows, one per memory space
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_win
         always_ff @(posedge clk) begin
            if (reset) begin
               user_lo_r[gi] <= `CMPG_USER_LO_RST;
               user_hi_r[gi] <= `CMPG_USER_HI_RST;
            end else if (mmu_wr && mode_r == cmpg_pkg::mode_system && mmu_space == gi) begin
               user_lo_r[gi] <= mmu_lo;
               user_hi_r[gi] <= mmu_hi;
            end
         end
         assign user_in[gi] = cpu_space == gi && cpu_addr >= user_lo_r[gi] && cpu_addr <= user_hi_r[gi];
      end
   endgenerate

   assign user_hit = |user_in;

   // sfr groups: everything for privileged modes, granted mask for user
   always_ff @(posedge clk) begin
      if (reset) begin
         sfr_mask_r <= `CMPG_SFR_MASK_RST;
         sfr_allow_r <= '0;
      end else begin
         if (sfr_wr && mode_r == cmpg_pkg::mode_system) begin
            sfr_mask_r <= sfr_mask;
         end
         sfr_allow_r <= mode_r == cmpg_pkg::mode_user ? sfr_mask_r : '1;
      end
   end

   always_comb begin
      cpu_allow = 1'b0;
      // rom is never writable, even in test mode
      if (cpu_rif.in_range && !(cpu_space == cmpg_pkg::space_rom && cpu_we)) begin
         unique case (mode_r)
            cmpg_pkg::mode_test: cpu_allow = 1'b1;
            cmpg_pkg::mode_boot: cpu_allow = cpu_rif.in_small;
            cmpg_pkg::mode_supfw: cpu_allow = cpu_rif.in_small;
            cmpg_pkg::mode_system: cpu_allow = !cpu_rif.in_small;
            cmpg_pkg::mode_user: cpu_allow = !cpu_rif.in_small && user_hit;
            default: cpu_allow = 1'b0;
         endcase
      end
   end

   // coprocessor: no window check, but small parts and the general ram stay closed
   assign cop_allow = cop_rif.in_range && !cop_rif.in_small && cop_rif.in_cop
      && cop_space != cmpg_pkg::space_rom;

   always_ff @(posedge clk) begin
      if (reset) begin
         mem_req_r <= 1'b0;
         mem_space_r <= cmpg_pkg::space_none;
         mem_addr_r <= 18'h00000;
         mem_we_r <= 1'b0;
         mem_wdata_r <= 8'h00;
         cpu_fault_r <= 1'b0;
      end else begin
         mem_req_r <= cpu_req && cpu_allow;
         mem_we_r <= cpu_req && cpu_allow && cpu_we;
         cpu_fault_r <= cpu_req && !cpu_allow;
         if (cpu_req && cpu_allow) begin
            mem_space_r <= cpu_space;
            mem_addr_r <= cpu_addr;
            mem_wdata_r <= cpu_wdata;
         end
      end
   end

   // blocked reads answer at once with zero data
   always_ff @(posedge clk) begin
      if (reset) begin
         cpu_rvalid_r <= 1'b0;
         cpu_rdata_r <= 8'h00;
      end else if (cpu_req && !cpu_allow && !cpu_we) begin
         cpu_rvalid_r <= 1'b1;
         cpu_rdata_r <= 8'h00;
      end else begin
         cpu_rvalid_r <= mem_rvalid;
         cpu_rdata_r <= mem_rvalid ? mem_rdata : 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cop_mem_req_r <= 1'b0;
         cop_mem_space_r <= cmpg_pkg::space_none;
         cop_mem_addr_r <= 18'h00000;
         cop_mem_we_r <= 1'b0;
         cop_fault_r <= 1'b0;
      end else begin
         cop_mem_req_r <= cop_req && cop_allow;
         cop_mem_we_r <= cop_req && cop_allow && cop_we;
         cop_fault_r <= cop_req && !cop_allow;
         if (cop_req && cop_allow) begin
            cop_mem_space_r <= cop_space;
            cop_mem_addr_r <= cop_addr;
         end
      end
   end

   // power states; the guard itself keeps running so wake is always seen
   always_ff @(posedge clk) begin
      if (reset) begin
         pwr_r <= cmpg_pkg::pwr_run;
         cpu_clk_en_r <= 1'b1;
         periph_clk_en_r <= 1'b1;
      end else begin
         unique case (pwr_r)
            cmpg_pkg::pwr_run: begin
               if (sleep_req) begin
                  pwr_r <= cmpg_pkg::pwr_sleep;
               end else if (idle_req) begin
                  pwr_r <= cmpg_pkg::pwr_idle;
               end
            end
            default: begin
               if (wake) begin
                  pwr_r <= cmpg_pkg::pwr_run;
               end
            end
         endcase
         cpu_clk_en_r <= pwr_r == cmpg_pkg::pwr_run;
         periph_clk_en_r <= pwr_r != cmpg_pkg::pwr_sleep;
      end
   end

   assign mode = mode_r;
   assign test_enabled = test_enabled_r;
   assign fuse_blow = fuse_blow_r;
   assign vec_load = vec_load_r;
   assign vec_pc = vec_pc_r;
   assign priv_refused = priv_refused_r;
   assign sfr_allow = sfr_allow_r;
   assign cpu_clk_en = cpu_clk_en_r;
   assign periph_clk_en = periph_clk_en_r;
   assign mem_req = mem_req_r;
   assign mem_space = mem_space_r;
   assign mem_addr = mem_addr_r;
   assign mem_we = mem_we_r;
   assign mem_wdata = mem_wdata_r;
   assign cpu_fault = cpu_fault_r;
   assign cpu_rvalid = cpu_rvalid_r;
   assign cpu_rdata = cpu_rdata_r;
   assign cop_mem_req = cop_mem_req_r;
   assign cop_mem_space = cop_mem_space_r;
   assign cop_mem_addr = cop_mem_addr_r;
   assign cop_mem_we = cop_mem_we_r;
   assign cop_fault = cop_fault_r;

   chk_boot_after_reset: assert property (@(posedge clk) $fell(reset) |-> mode_r == cmpg_pkg::mode_boot)
      else $error("mode not boot after reset");

   chk_startup_end: assert property (@(posedge clk) disable iff (reset)
      mode_r == cmpg_pkg::mode_boot && boot_done && !test_lock_req
      |=> mode_r == (test_enabled_r ? cmpg_pkg::mode_test : cmpg_pkg::mode_system))
      else $error("start-up ended in wrong mode");

   chk_blocked_access: assert property (@(posedge clk) disable iff (reset)
      cpu_req && !cpu_allow |=> cpu_fault_r && !mem_req_r && cpu_rdata_r == 8'h00)
      else $error("blocked access reached memory");

   chk_test_full_access: assert property (@(posedge clk) disable iff (reset)
      cpu_req && mode_r == cmpg_pkg::mode_test && cpu_rif.in_range && !cpu_we |=> mem_req_r)
      else $error("test mode access refused");

   chk_priv_small_only: assert property (@(posedge clk) disable iff (reset)
      cpu_req && (mode_r == cmpg_pkg::mode_boot || mode_r == cmpg_pkg::mode_supfw) && !cpu_rif.in_small
      |=> cpu_fault_r)
      else $error("privileged firmware left small parts");

   chk_app_large_only: assert property (@(posedge clk) disable iff (reset)
      cpu_req && sysuser && cpu_rif.in_small |=> cpu_fault_r && !mem_req_r)
      else $error("application reached reserved part");

   chk_cfg_call_mode: assert property (@(posedge clk) disable iff (reset)
      sysuser && !vec_take && call_req && call_cfg && call_num < `CMPG_CFG_CALLS
      |=> mode_r == cmpg_pkg::mode_supfw && vec_load_r)
      else $error("configuration call did not enter support mode");

   chk_vector_mode: assert property (@(posedge clk) disable iff (reset)
      sysuser && vec_take |=> vec_load_r && (mode_r == cmpg_pkg::mode_system || mode_r == cmpg_pkg::mode_user))
      else $error("vector entered wrong mode");

   chk_window_guard: assert property (@(posedge clk) disable iff (reset)
      mmu_wr && mode_r != cmpg_pkg::mode_system |=> priv_refused_r && $stable(user_lo_r[0]))
      else $error("window written outside system mode");

   chk_cop_region: assert property (@(posedge clk) disable iff (reset)
      cop_req && cop_space == cmpg_pkg::space_ram && cop_addr < `CMPG_RAM_COP_START |=> cop_fault_r && !cop_mem_req_r)
      else $error("coprocessor reached general ram");

   chk_test_lock: assert property (@(posedge clk) disable iff (reset)
      locked_r |-> mode_r != cmpg_pkg::mode_test && !test_enabled_r)
      else $error("test mode alive after lock");

   chk_sleep_clock: assert property (@(posedge clk) disable iff (reset)
      pwr_r == cmpg_pkg::pwr_sleep |=> !periph_clk_en_r && !cpu_clk_en_r)
      else $error("clock running in sleep");

endmodule

`default_nettype wire

// >>> cmpg_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module cmpg_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // guarded memory side
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [17:0] mem_addr,
   output logic mem_rvalid,
   output logic [7:0] mem_rdata
);
   // idle data flips each cycle so a stale byte never looks valid
   always_ff @(posedge clk) begin
      if (reset) begin
         mem_rvalid <= 1'b0;
         mem_rdata <= 8'h00;
      end else if (mem_req && !mem_we) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= mem_addr[7:0] ^ 8'h5a;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic clk, reset, test_fuse_pin, ram_cfg_pin, boot_done, test_lock_req, vec_take;
   logic call_req, call_cfg, call_ret, user_enter, mmu_wr, sfr_wr, idle_req, sleep_req;
   logic wake, cpu_req, cpu_we, cop_req, cop_we, mem_rvalid, test_enabled, fuse_blow;
   logic vec_load, priv_refused, cpu_clk_en, periph_clk_en, mem_req, mem_we, cpu_fault;
   logic cpu_rvalid, cop_mem_req, cop_mem_we, cop_fault;
   logic [1:0] nv_cfg_pin;
   logic [4:0] vec_src, call_num;
   logic [17:0] mmu_lo, mmu_hi, cpu_addr, cop_addr, mem_addr, vec_pc, cop_mem_addr;
   logic [7:0] sfr_mask, cpu_wdata, mem_rdata, mem_wdata, cpu_rdata, sfr_allow;
   cmpg_pkg::cmpg_space_t mmu_space, cpu_space, cop_space, mem_space, cop_mem_space;
   cmpg_pkg::cmpg_mode_t mode;
   int n_mismatch = 0;
   int samples_checked = 0;

   // source 31 is a user-mode vector so both vector targets get exercised
   cmpg_guard #(.USER_VEC_MASK(32'h80000000)) DUT (.clk, .reset, .test_fuse_pin, .nv_cfg_pin, .ram_cfg_pin, .boot_done,
      .test_lock_req, .vec_take, .vec_src, .call_req, .call_cfg, .call_num, .call_ret,
      .user_enter, .mmu_wr, .mmu_space, .mmu_lo, .mmu_hi, .sfr_wr, .sfr_mask, .idle_req,
      .sleep_req, .wake, .cpu_req, .cpu_space, .cpu_addr, .cpu_we, .cpu_wdata, .cop_req,
      .cop_space, .cop_addr, .cop_we, .mem_rvalid, .mem_rdata, .mode, .test_enabled,
      .fuse_blow, .vec_load, .vec_pc, .priv_refused, .sfr_allow, .cpu_clk_en,
      .periph_clk_en, .mem_req, .mem_space, .mem_addr, .mem_we, .mem_wdata, .cpu_fault,
      .cpu_rvalid, .cpu_rdata, .cop_mem_req, .cop_mem_space, .cop_mem_addr, .cop_mem_we,
      .cop_fault);
   cmpg_mem_model mem (.clk, .reset, .mem_req, .mem_we, .mem_addr, .mem_rvalid, .mem_rdata);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic final_report;
      if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // leading wait keeps two strobes of one signal a cycle apart;
   // returns at the falling edge right after the answer edge
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic acc(input cmpg_pkg::cmpg_space_t sp, input logic [17:0] a,
                      input logic we, input logic ok);
      cpu_space = sp;
      cpu_addr = a;
      cpu_we = we;
      cpu_wdata = a[7:0] ^ 8'h3c;
      pulse(cpu_req);
      chk({mem_req, mem_we, cpu_fault}, {ok, ok && we, !ok});
      if (ok) chk({mem_space, mem_addr, mem_wdata}, {sp, a, a[7:0] ^ 8'h3c});
      if (!ok && !we) chk({cpu_rvalid, cpu_rdata}, 9'h100);
      if (ok && !we) begin
         repeat (2) @(negedge clk);
         chk({cpu_rvalid, cpu_rdata}, {1'b1, a[7:0] ^ 8'h5a});
      end
   endtask

   task automatic cop(input cmpg_pkg::cmpg_space_t sp, input logic [17:0] a,
                      input logic we, input logic ok);
      cop_space = sp;
      cop_addr = a;
      cop_we = we;
      pulse(cop_req);
      chk({cop_mem_req, cop_mem_we, cop_fault}, {ok, ok && we, !ok});
      if (ok) chk({cop_mem_space, cop_mem_addr}, {sp, a});
   endtask

   task automatic t_boot_test;
      chk(mode, cmpg_pkg::mode_boot);
      repeat (3) @(negedge clk);
      pulse(boot_done);
      chk({test_enabled, mode}, {1'b1, cmpg_pkg::mode_test});
      acc(cmpg_pkg::space_rom, 18'h00100, 1'b0, 1'b1);
      acc(cmpg_pkg::space_ram, 18'h00010, 1'b0, 1'b1);
      acc(cmpg_pkg::space_rom, 18'h00100, 1'b1, 1'b0);
      pulse(test_lock_req);
      chk({fuse_blow, test_enabled, mode}, {2'b10, cmpg_pkg::mode_system});
   endtask

   task automatic t_system;
      acc(cmpg_pkg::space_ram, 18'h0007f, 1'b0, 1'b0);
      acc(cmpg_pkg::space_ram, 18'h00080, 1'b0, 1'b1);
      acc(cmpg_pkg::space_ram, 18'h01800, 1'b0, 1'b0);
      acc(cmpg_pkg::space_rom, 18'h31fff, 1'b0, 1'b1);
      acc(cmpg_pkg::space_rom, 18'h32000, 1'b0, 1'b0);
      acc(cmpg_pkg::space_nv, 18'h0107f, 1'b0, 1'b0);
      acc(cmpg_pkg::space_nv, 18'h01080, 1'b1, 1'b1);
   endtask

   task automatic t_vectors;
      vec_src = 5'h05;
      pulse(vec_take);
      chk({vec_load, vec_pc, mode}, {1'b1, 18'h0002b, cmpg_pkg::mode_system});
      call_num = 5'h1f;
      pulse(call_req);
      chk({vec_pc, mode}, {18'h002f8, cmpg_pkg::mode_system});
      call_cfg = 1'b1;
      call_num = 5'h07;
      pulse(call_req);
      chk({vec_pc, mode}, {18'h32038, cmpg_pkg::mode_supfw});
      acc(cmpg_pkg::space_rom, 18'h32000, 1'b0, 1'b1);
      acc(cmpg_pkg::space_ram, 18'h00080, 1'b0, 1'b0);
      pulse(call_ret);
      call_num = 5'h08;
      pulse(call_req);
      chk({priv_refused, mode}, {1'b1, cmpg_pkg::mode_system});
   endtask

   task automatic t_user;
      mmu_space = cmpg_pkg::space_ram;
      mmu_lo = 18'h00100;
      mmu_hi = 18'h001ff;
      pulse(mmu_wr);
      sfr_mask = 8'h0f;
      pulse(sfr_wr);
      pulse(user_enter);
      @(negedge clk);
      chk({sfr_allow, mode}, {8'h0f, cmpg_pkg::mode_user});
      acc(cmpg_pkg::space_ram, 18'h001ff, 1'b0, 1'b1);
      acc(cmpg_pkg::space_ram, 18'h00200, 1'b0, 1'b0);
      // a refused reprogramming must leave the old window in place
      mmu_lo = 18'h00200;
      mmu_hi = 18'h002ff;
      pulse(mmu_wr);
      chk(priv_refused, 1'b1);
      acc(cmpg_pkg::space_ram, 18'h00200, 1'b0, 1'b0);
      cop(cmpg_pkg::space_ram, 18'h00e00, 1'b1, 1'b1);
      cop(cmpg_pkg::space_ram, 18'h00dff, 1'b0, 1'b0);
      cop(cmpg_pkg::space_nv, 18'h01080, 1'b0, 1'b1);
      cop(cmpg_pkg::space_nv, 18'h0107f, 1'b1, 1'b0);
      cop(cmpg_pkg::space_rom, 18'h00100, 1'b0, 1'b0);
      vec_src = 5'h1f;
      pulse(vec_take);
      chk({vec_load, vec_pc, mode}, {1'b1, 18'h000fb, cmpg_pkg::mode_user});
   endtask

   // second start-up with the fuse reading blown and the other strap split
   task automatic t_restart;
      test_fuse_pin = 1'b1;
      nv_cfg_pin = 2'h1;
      ram_cfg_pin = 1'b0;
      reset = 1'b1;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      chk({test_enabled, mode}, {1'b0, cmpg_pkg::mode_boot});
      repeat (2) @(negedge clk);
      pulse(boot_done);
      chk({test_enabled, mode, sfr_allow}, {1'b0, cmpg_pkg::mode_system, 8'hff});
      acc(cmpg_pkg::space_ram, 18'h00000, 1'b0, 1'b1);
      acc(cmpg_pkg::space_nv, 18'h0047f, 1'b0, 1'b0);
      acc(cmpg_pkg::space_nv, 18'h00480, 1'b1, 1'b1);
   endtask

   task automatic t_power;
      pulse(idle_req);
      @(negedge clk);
      chk({cpu_clk_en, periph_clk_en}, 2'b01);
      pulse(wake);
      @(negedge clk);
      chk({cpu_clk_en, periph_clk_en}, 2'b11);
      pulse(sleep_req);
      @(negedge clk);
      chk({cpu_clk_en, periph_clk_en}, 2'b00);
      pulse(wake);
      @(negedge clk);
      chk({cpu_clk_en, periph_clk_en}, 2'b11);
   endtask

   initial begin
      {test_fuse_pin, boot_done, test_lock_req, vec_take, call_req, call_cfg} = '0;
      {call_ret, user_enter, mmu_wr, sfr_wr, idle_req, sleep_req, wake} = '0;
      {cpu_req, cpu_we, cop_req, cop_we, vec_src, call_num, mmu_lo, mmu_hi} = '0;
      {cpu_addr, cop_addr, sfr_mask, cpu_wdata} = '0;
      mmu_space = cmpg_pkg::space_none;
      cpu_space = cmpg_pkg::space_none;
      cop_space = cmpg_pkg::space_none;
      nv_cfg_pin = 2'h2;
      ram_cfg_pin = 1'b1;
      reset = 1'b1;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      t_boot_test;
      t_system;
      t_vectors;
      t_user;
      t_restart;
      t_power;
      final_report;
   end

   // whole run is about 110 cycles
   initial begin
      #20000;
      n_mismatch++;
      final_report;
   end
endmodule

`default_nettype wire
